// ---- design/otc_pkg.sv ----
// Shared constants, register map and helper functions for the overtemperature timer block.
package otc_pkg;

	// Clock and timer step; the step count is derived so only the printed figure is kept.
	localparam int  CLK_PERIOD_NS   = 5;
	localparam real STEP_TIME_MS    = 22.76;
	localparam int  STEP_CYCLES     = int'(STEP_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
	// Durations shorter than two steps (45.52 ms) report only the assertion flag.
	localparam logic [7:0] REPORT_MIN_STEPS = 8'h02;
	localparam logic [7:0] COUNT_MAX        = 8'hff;

	// Bus geometry and responses.
	localparam int         ADDR_W      = 10;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_INT_STATUS2 = 8'h42;
	localparam logic [7:0] IDX_DUR_STATUS  = 8'h79;
	localparam logic [7:0] IDX_DUR_LIMIT   = 8'h7a;
	localparam logic [7:0] IDX_PULSE_SEL   = 8'h7b;
	localparam logic [7:0] IDX_TEMP_CFG    = 8'h7c;
	localparam logic [7:0] IDX_LOCK_CTRL   = 8'h80;
	localparam logic [7:0] IDX_INT_CLEAR   = 8'h81;
	localparam logic [7:0] IDX_INT_ENABLE  = 8'h82;
	localparam logic [7:0] IDX_PIN_DATA    = 8'h83;

	// Values after reset.
	localparam logic [7:0] RST_DUR_LIMIT  = 8'h00;
	localparam logic [7:0] RST_PULSE_SEL  = 8'h55;
	localparam logic [7:0] RST_TEMP_CFG   = 8'h01;
	localparam logic [7:0] RST_INT_ENABLE = 8'h00;

	// Field positions.
	localparam int CFG_TWOS_BIT    = 0;
	localparam int CFG_OFFSET_BIT  = 1;
	localparam int CFG_DIR_BIT     = 2;
	localparam int CFG_POL_BIT     = 3;
	localparam int CFG_VID_BIT     = 4;
	localparam int CFG_CHAN_LSB    = 5;
	localparam int INT_TIMEOUT_BIT = 5;
	localparam int LOCK_BIT        = 0;
	localparam int PIN_OUT_BIT     = 0;
	localparam int PIN_IN_BIT      = 1;

	// Limit codes that switch a channel's overtemperature output off.
	localparam logic [7:0]        LIMIT_OFF_OFFSET64 = 8'h00;
	localparam logic [7:0]        LIMIT_OFF_TWOS     = 8'h80;
	localparam logic signed [9:0] OFFSET64_BIAS      = 10'sh040;

	// Converts a temperature code to signed degrees under the selected encoding.
	function automatic logic signed [9:0] otc_to_celsius(input logic [7:0] code,
			input logic twos);
		if (twos) begin
			return $signed({{2{code[7]}}, code});
		end
		return $signed({2'h0, code}) - OFFSET64_BIAS;
	endfunction

	// True when a limit code holds the disabling value for the selected encoding.
	function automatic logic otc_limit_off(input logic [7:0] code, input logic twos);
		return twos ? (code == LIMIT_OFF_TWOS) : (code == LIMIT_OFF_OFFSET64);
	endfunction

	// True for every index that answers on the bus.
	function automatic logic otc_is_mapped(input logic [7:0] idx);
		return idx inside {IDX_INT_STATUS2, IDX_DUR_STATUS, IDX_DUR_LIMIT, IDX_PULSE_SEL,
			IDX_TEMP_CFG, IDX_LOCK_CTRL, IDX_INT_CLEAR, IDX_INT_ENABLE, IDX_PIN_DATA};
	endfunction

endpackage

// ---- design/otc_sync2.sv ----
// Two-flop synchroniser for a single level arriving from outside the clock domain.
`timescale 1ns/1ps
module otc_sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic asyncIn,
	output logic      syncOut
);

	logic meta_r;

	// The first stage feeds only the second stage to contain metastability.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_r  <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			meta_r  <= asyncIn;
			syncOut <= meta_r;
		end
	end

endmodule

// ---- design/otc_overtemp_timer.sv ----
// Overtemperature duration timer, limit compare, pin and temperature configuration registers.
//
// Operation
// - Bits 7:1 of the duration status time the assertion and read zero up to 45.52 ms.
// - Status bit 0 sets when the overtemperature input asserts and clears on read.
// - Past 45.52 ms bit 0 becomes the LSB of an 8-bit count in 22.76 ms steps up to 5.80 s.
// - When the duration exceeds the 8-bit limit, timeout flag bit 5 of interrupt status two sets.
// - A limit of zero raises the timeout flag at the very assertion of the overtemperature input.
// - Pulse select holds four 2-bit fields, codes 0..3 for 1..4 pulses, default 01.
// - Config bit 0 selects two's complement (1) or offset-64 (0) for all temperature values.
// - Config bit 1 selects the offset range: 0.5 degree steps when 0, 1 degree steps when 1.
// - Configuration bit 2 makes the sixth general pin an input (0) or output (1) when enabled.
// - Configuration bit 3 makes the sixth general pin output active low (0) or high (1).
// - Configuration bit 4 gives five shared pins voltage-ID (0) or general-purpose (1) function.
// - Configuration bits 5..7 let each channel's limit drive the overtemperature signal.
// - A channel limit of -64 C (offset-64) or -128 C (two's complement) disables that channel.
// - Once the lock bit is set the configuration register ignores all writes.
`timescale 1ns/1ps
module otc_overtemp_timer #(
	parameter int STEP_CYCLES = otc_pkg::STEP_CYCLES
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic [otc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [otc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      overtempSignalIn_n,
	output logic                           overtempSignalOut,
	output logic                           overtempSignalOe,
	input  wire logic [7:0]                remoteOneTemp,
	input  wire logic [7:0]                localTemp,
	input  wire logic [7:0]                remoteTwoTemp,
	input  wire logic [7:0]                remoteOneLimit,
	input  wire logic [7:0]                localLimit,
	input  wire logic [7:0]                remoteTwoLimit,
	input  wire logic                      sixthPinFuncEn,
	input  wire logic                      sixthGeneralPinIn,
	output logic                           sixthGeneralPinOut,
	output logic                           sixthGeneralPinOe,
	output logic                           twosComplementSelect,
	output logic                           offsetRangeSelect,
	output logic                           voltageIdPinSelect,
	output logic [1:0]                     firstFanPulseSel,
	output logic [1:0]                     secondFanPulseSel,
	output logic [1:0]                     thirdFanPulseSel,
	output logic [1:0]                     fourthFanPulseSel,
	output logic                           irq
);

	logic        overtempSync;
	logic        pinInSync;
	logic        otActive;
	logic        otPrev_r;
	logic        assertEdge;
	logic [31:0] prescale_r;
	logic        stepTick;
	logic [7:0]  durationCount_r;
	logic        assertFlag_r;
	logic [7:0]  durationStatus;
	logic        timeoutHit;
	logic [7:0]  durationLimit_r;
	logic [7:0]  pulseSel_r;
	logic [7:0]  tempCfg_r;
	logic        lock_r;
	logic [7:0]  intStatus_r;
	logic [7:0]  intEnable_r;
	logic        pinOutValue_r;
	logic        overtempDrive_r;
	logic        overtempDrive_nxt;
	logic [7:0]  chanTemp [3];
	logic [7:0]  chanLimit [3];
	localparam int ADDR_IDX_W = 8;
	logic [ADDR_IDX_W-1:0] awIdx_r;
	logic        awHeld_r;
	logic [7:0]  wData_r;
	logic        wLane0_r;
	logic        wHeld_r;
	logic        doWrite;
	logic        wrLegal;
	logic [7:0]  arIdx;
	logic        readTaken;
	logic [7:0]  readValue;
	logic        statusRead;

	// Both pins arrive from outside, so they are synchronised before any logic sees them.
	otc_sync2 #(
		.RESET_VAL (1'b1)
	) u_overtemp_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.asyncIn (overtempSignalIn_n),
		.syncOut (overtempSync)
	);

	otc_sync2 #(
		.RESET_VAL (1'b0)
	) u_pin_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.asyncIn (sixthGeneralPinIn),
		.syncOut (pinInSync)
	);

	// The overtemperature signal is active low on the wire.
	assign otActive   = ~overtempSync;
	assign assertEdge = otActive & ~otPrev_r;
	assign stepTick   = otActive & ~assertEdge & (prescale_r == 32'(STEP_CYCLES - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			otPrev_r <= 1'b0;
		end else begin
			otPrev_r <= otActive;
		end
	end

	// Step prescaler restarts at every new assertion so steps are measured from the edge.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prescale_r <= 32'h0;
		end else if (!otActive || assertEdge || stepTick) begin
			prescale_r <= 32'h0;
		end else begin
			prescale_r <= prescale_r + 32'h1;
		end
	end

	// Duration of the latest assertion in steps; it is held after release for software.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			durationCount_r <= 8'h0;
		end else if (assertEdge) begin
			durationCount_r <= 8'h0;
		end else if (stepTick && durationCount_r != otc_pkg::COUNT_MAX) begin
			durationCount_r <= durationCount_r + 8'h1;
		end
	end

	// A new assertion in the same cycle as the clearing read keeps the flag set.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			assertFlag_r <= 1'b0;
		end else if (assertEdge) begin
			assertFlag_r <= 1'b1;
		end else if (statusRead) begin
			assertFlag_r <= 1'b0;
		end
	end

	// Short assertions show only the flag; long ones show the whole count.
	assign durationStatus = (durationCount_r >= otc_pkg::REPORT_MIN_STEPS) ?
		durationCount_r : {7'h0, assertFlag_r};

	// The stale count from the previous assertion is ignored in the edge cycle.
	assign timeoutHit = (assertEdge && durationLimit_r == 8'h0) ||
		(otActive && !assertEdge && durationCount_r > durationLimit_r);

	// Sticky interrupt status; a hardware set wins over a software clear.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			intStatus_r <= 8'h0;
		end else begin
			if (doWrite && wrLegal && awIdx_r == otc_pkg::IDX_INT_CLEAR) begin
				intStatus_r <= intStatus_r & ~wData_r;
			end
			if (timeoutHit) begin
				intStatus_r[otc_pkg::INT_TIMEOUT_BIT] <= 1'b1;
			end
		end
	end

	assign irq = |(intStatus_r & intEnable_r);

	// Write path: address and data are taken independently, the response follows both.
	assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
	assign doWrite       = awHeld_r & wHeld_r & ~s_axi_bvalid;
	assign wrLegal       = wLane0_r & otc_pkg::otc_is_mapped(awIdx_r);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			awIdx_r  <= 8'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_r <= 1'b1;
			awIdx_r  <= s_axi_awaddr[9:2];
		end else if (doWrite) begin
			awHeld_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wHeld_r  <= 1'b0;
			wData_r  <= 8'h0;
			wLane0_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_r  <= 1'b1;
			wData_r  <= s_axi_wdata[7:0];
			wLane0_r <= s_axi_wstrb[0];
		end else if (doWrite) begin
			wHeld_r <= 1'b0;
		end
	end

	// Unmapped indices answer with an error and change nothing.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= otc_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= otc_pkg::otc_is_mapped(awIdx_r) ?
				otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Duration limit, pulse select, interrupt enable and pin output data registers.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			durationLimit_r <= otc_pkg::RST_DUR_LIMIT;
			pulseSel_r      <= otc_pkg::RST_PULSE_SEL;
			intEnable_r     <= otc_pkg::RST_INT_ENABLE;
			pinOutValue_r   <= 1'b0;
		end else if (doWrite && wrLegal) begin
			unique case (awIdx_r)
				otc_pkg::IDX_DUR_LIMIT:  durationLimit_r <= wData_r;
				otc_pkg::IDX_PULSE_SEL:  pulseSel_r      <= wData_r;
				otc_pkg::IDX_INT_ENABLE: intEnable_r     <= wData_r;
				otc_pkg::IDX_PIN_DATA:   pinOutValue_r   <= wData_r[otc_pkg::PIN_OUT_BIT];
				default: ;
			endcase
		end
	end

	// The lock can only be released by reset, which is what makes it a protection.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lock_r <= 1'b0;
		end else if (doWrite && wrLegal && awIdx_r == otc_pkg::IDX_LOCK_CTRL &&
				wData_r[otc_pkg::LOCK_BIT]) begin
			lock_r <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tempCfg_r <= otc_pkg::RST_TEMP_CFG;
		end else if (doWrite && wrLegal && !lock_r && awIdx_r == otc_pkg::IDX_TEMP_CFG) begin
			tempCfg_r <= wData_r;
		end
	end

	// Configuration fields go straight out to the measurement and pin logic.
	assign twosComplementSelect = tempCfg_r[otc_pkg::CFG_TWOS_BIT];
	assign offsetRangeSelect    = tempCfg_r[otc_pkg::CFG_OFFSET_BIT];
	assign voltageIdPinSelect   = tempCfg_r[otc_pkg::CFG_VID_BIT];
	assign firstFanPulseSel     = pulseSel_r[1:0];
	assign secondFanPulseSel    = pulseSel_r[3:2];
	assign thirdFanPulseSel     = pulseSel_r[5:4];
	assign fourthFanPulseSel    = pulseSel_r[7:6];

	// Sixth general pin: drives only when its function is on and it is set as output.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sixthGeneralPinOe  <= 1'b0;
			sixthGeneralPinOut <= 1'b0;
		end else begin
			sixthGeneralPinOe  <= sixthPinFuncEn & tempCfg_r[otc_pkg::CFG_DIR_BIT];
			sixthGeneralPinOut <= tempCfg_r[otc_pkg::CFG_POL_BIT] ?
				pinOutValue_r : ~pinOutValue_r;
		end
	end

	assign chanTemp[0]  = remoteOneTemp;
	assign chanTemp[1]  = localTemp;
	assign chanTemp[2]  = remoteTwoTemp;
	assign chanLimit[0] = remoteOneLimit;
	assign chanLimit[1] = localLimit;
	assign chanLimit[2] = remoteTwoLimit;

	// Codes are reinterpreted under the current encoding every cycle, so a change of
	// encoding takes effect on the very next compare.
	always_comb begin
		overtempDrive_nxt = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (tempCfg_r[otc_pkg::CFG_CHAN_LSB + i] &&
					!otc_pkg::otc_limit_off(chanLimit[i], twosComplementSelect) &&
					otc_pkg::otc_to_celsius(chanTemp[i], twosComplementSelect) >
					otc_pkg::otc_to_celsius(chanLimit[i], twosComplementSelect)) begin
				overtempDrive_nxt = 1'b1;
			end
		end
	end

	// Open-drain output: the wire is only ever pulled low, and the timer sees our own drive.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			overtempDrive_r <= 1'b0;
		end else begin
			overtempDrive_r <= overtempDrive_nxt;
		end
	end

	assign overtempSignalOe  = overtempDrive_r;
	assign overtempSignalOut = 1'b0;

	// Read path: one read at a time, data registered with the response.
	assign s_axi_arready = ~s_axi_rvalid;
	assign arIdx         = s_axi_araddr[9:2];
	assign readTaken     = s_axi_arvalid & s_axi_arready;
	assign statusRead    = readTaken & (arIdx == otc_pkg::IDX_DUR_STATUS);

	always_comb begin
		unique case (arIdx)
			otc_pkg::IDX_INT_STATUS2: readValue = intStatus_r;
			otc_pkg::IDX_DUR_STATUS:  readValue = durationStatus;
			otc_pkg::IDX_DUR_LIMIT:   readValue = durationLimit_r;
			otc_pkg::IDX_PULSE_SEL:   readValue = pulseSel_r;
			otc_pkg::IDX_TEMP_CFG:    readValue = tempCfg_r;
			otc_pkg::IDX_LOCK_CTRL:   readValue = {7'h0, lock_r};
			otc_pkg::IDX_INT_ENABLE:  readValue = intEnable_r;
			otc_pkg::IDX_PIN_DATA:    readValue = {6'h0, pinInSync, pinOutValue_r};
			default:                  readValue = 8'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= otc_pkg::RESP_OKAY;
		end else if (readTaken) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h0, readValue};
			s_axi_rresp  <= otc_pkg::otc_is_mapped(arIdx) ?
				otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ---- sim/otc_wire_model.sv ----
// Far-side model of the shared overtemperature wire with its pull-up.
`timescale 1ns/1ps
module otc_wire_model (
	input  wire logic extAssert,
	input  wire logic dutOe,
	output logic      wireLevel_n
);
	// Either party may pull the wire low; otherwise the pull-up holds it high, so it never floats.
	assign wireLevel_n = !(extAssert || dutOe);
endmodule

// ---- sim/otc_overtemp_timer_assertions.sv ----
// Port-level checker for the overtemperature timer block.
`timescale 1ns/1ps
module otc_overtemp_timer_chk (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       s_axi_bvalid,
	input wire logic       overtempSignalOut,
	input wire logic       overtempSignalOe,
	input wire logic [7:0] remoteOneTemp,
	input wire logic [7:0] localTemp,
	input wire logic [7:0] remoteTwoTemp,
	input wire logic [7:0] remoteOneLimit,
	input wire logic [7:0] localLimit,
	input wire logic [7:0] remoteTwoLimit,
	input wire logic       sixthPinFuncEn,
	input wire logic       sixthGeneralPinOe,
	input wire logic       twosComplementSelect,
	input wire logic       offsetRangeSelect,
	input wire logic       voltageIdPinSelect,
	input wire logic [1:0] firstFanPulseSel,
	input wire logic [1:0] secondFanPulseSel,
	input wire logic [1:0] thirdFanPulseSel,
	input wire logic [1:0] fourthFanPulseSel,
	input wire logic       irq
);
	logic hot;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// True when a channel reading is over a limit that is not the disabling code.
	function automatic logic over(input logic [7:0] t, input logic [7:0] l, input logic tw);
		if (tw) begin
			return ($signed(t) > $signed(l)) && (l != 8'h80);
		end
		return (t > l) && (l != 8'h00);
	endfunction

	// Channel enables are not visible here, so only the necessary cause is checked.
	always_comb begin
		hot = over(remoteOneTemp, remoteOneLimit, twosComplementSelect) |
			over(localTemp, localLimit, twosComplementSelect) |
			over(remoteTwoTemp, remoteTwoLimit, twosComplementSelect);
	end

	property p_od_low;
		overtempSignalOut == 1'b0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("overtemp output drives high");
	property p_oe_cause;
		overtempSignalOe |-> $past(hot);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("overtemp pull-down without cause");
	property p_pin_oe;
		sixthGeneralPinOe |-> $past(sixthPinFuncEn);
	endproperty
	a_pin_oe: assert property (p_pin_oe) else $error("sixth pin driven while disabled");
	property p_twos_wr;
		$changed(twosComplementSelect) |-> $rose(s_axi_bvalid);
	endproperty
	a_twos_wr: assert property (p_twos_wr) else $error("encoding changed without write");
	property p_offs_wr;
		$changed(offsetRangeSelect) |-> $rose(s_axi_bvalid);
	endproperty
	a_offs_wr: assert property (p_offs_wr) else $error("offset range changed without write");
	property p_vid_wr;
		$changed(voltageIdPinSelect) |-> $rose(s_axi_bvalid);
	endproperty
	a_vid_wr: assert property (p_vid_wr) else $error("pin function changed without write");
	property p_fan_wr;
		$changed({fourthFanPulseSel, thirdFanPulseSel, secondFanPulseSel, firstFanPulseSel})
			|-> $rose(s_axi_bvalid);
	endproperty
	a_fan_wr: assert property (p_fan_wr) else $error("pulse selection changed without write");
	property p_irq_fall;
		$fell(irq) |-> $rose(s_axi_bvalid);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
endmodule

bind otc_overtemp_timer otc_overtemp_timer_chk chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
	.overtempSignalOut(overtempSignalOut), .overtempSignalOe(overtempSignalOe),
	.remoteOneTemp(remoteOneTemp), .localTemp(localTemp), .remoteTwoTemp(remoteTwoTemp),
	.remoteOneLimit(remoteOneLimit), .localLimit(localLimit), .remoteTwoLimit(remoteTwoLimit),
	.sixthPinFuncEn(sixthPinFuncEn), .sixthGeneralPinOe(sixthGeneralPinOe),
	.twosComplementSelect(twosComplementSelect), .offsetRangeSelect(offsetRangeSelect),
	.voltageIdPinSelect(voltageIdPinSelect), .firstFanPulseSel(firstFanPulseSel),
	.secondFanPulseSel(secondFanPulseSel), .thirdFanPulseSel(thirdFanPulseSel),
	.fourthFanPulseSel(fourthFanPulseSel), .irq(irq)
);

// ---- sim/overtemp_timer_and_config_tb_top.sv ----
// Self-checking bench with register bus tasks and a reference register model.
`timescale 1ns/1ps
module overtemp_timer_and_config_tb_top;
	localparam int         STEP       = 8;
	localparam logic [7:0] RIDX [7]   = '{8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h42, 8'h82, 8'h81};
	localparam int         KS [5]     = '{0, 1, 2, 5, 300};
	logic        ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awready, wready, bvalid, arready, rvalid, otExt, wireN, otOut, otOe;
	logic [1:0]  bresp, rresp, f1, f2, f3, f4;
	logic [7:0]  t1, t2, t3, l1, l2, l3;
	logic        funcEn, pinIn, pinOut, pinOe, twos, offs, vid, irq, locked;
	int          err_count, samples_checked, mdl [256];

	otc_overtemp_timer #(.STEP_CYCLES(STEP)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.overtempSignalIn_n(wireN), .overtempSignalOut(otOut), .overtempSignalOe(otOe),
		.remoteOneTemp(t1), .localTemp(t2), .remoteTwoTemp(t3), .remoteOneLimit(l1),
		.localLimit(l2), .remoteTwoLimit(l3), .sixthPinFuncEn(funcEn),
		.sixthGeneralPinIn(pinIn), .sixthGeneralPinOut(pinOut), .sixthGeneralPinOe(pinOe),
		.twosComplementSelect(twos), .offsetRangeSelect(offs), .voltageIdPinSelect(vid),
		.firstFanPulseSel(f1), .secondFanPulseSel(f2), .thirdFanPulseSel(f3),
		.fourthFanPulseSel(f4), .irq(irq)
	);
	otc_wire_model wire_u (.extAssert(otExt), .dutOe(otOe), .wireLevel_n(wireN));

	// Compares one result and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Offers address and data together; the trailing edge keeps drivers from double assigning.
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
		logic a;
		logic w;
		a = 1'b1;
		w = 1'b1;
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (a || w) begin
			@(posedge ref_clk);
			if (a && awready === 1'b1) begin
				a = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		if (er == 2'h0 && !(i == 8'h7c && locked)) begin
			mdl[i] = d;
		end
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] ed, input logic [1:0] er);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, 32'(ed));
		chk(32'(rresp), 32'(er));
		@(posedge ref_clk);
	endtask

	// The external sensor holds the wire low for n cycles, then the synchronisers settle.
	task automatic ot(input int n);
		otExt <= 1'b1;
		repeat (n) @(posedge ref_clk);
		otExt <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask

	function automatic logic hot(input logic [7:0] t, input logic [7:0] l, input logic tw);
		if (tw) begin
			return ($signed(t) > $signed(l)) && (l != 8'h80);
		end
		return (t > l) && (l != 8'h00);
	endfunction

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Whole run needs about 3000 cycles, so this bound only fires on a hang.
	initial begin
		repeat (30000) @(posedge ref_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		int k;
		logic [7:0] c;
		logic tw;
		{rst_n, awvalid, wvalid, bready, arvalid, rready, otExt, funcEn, pinIn} = '0;
		{awaddr, araddr, wdata, t1, t2, t3, l1, l2, l3} = '0;
		locked = 1'b0;
		mdl[8'h7b] = 8'h55;
		mdl[8'h7c] = 8'h01;
		k = $urandom(45);
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (RIDX[j]) rd(RIDX[j], 8'(mdl[RIDX[j]]), 2'h0);
		chk(32'({f4, f3, f2, f1}), 32'h55);
		wr(8'h10, 8'h5a, 2'h2);
		rd(8'h10, 8'h00, 2'h2);
		for (k = 0; k < 4; k++) begin
			c = {4{2'(k)}};
			wr(8'h7b, c, 2'h0);
			rd(8'h7b, c, 2'h0);
			chk(32'({f4, f3, f2, f1}), 32'(c));
		end
		for (k = 0; k < 4; k++) begin
			c = 8'($urandom) & 8'h1f;
			wr(8'h7c, c, 2'h0);
			rd(8'h7c, c, 2'h0);
			chk(32'({vid, offs, twos}), 32'({c[4], c[1], c[0]}));
		end
		funcEn <= 1'b1;
		pinIn <= 1'b1;
		wr(8'h83, 8'h01, 2'h0);
		for (k = 0; k < 2; k++) begin
			wr(8'h7c, 8'h05 | 8'(k << 3), 2'h0);
			chk(32'({pinOe, pinOut}), 32'({1'b1, k[0]}));
		end
		rd(8'h83, 8'h03, 2'h0);
		wr(8'h7c, 8'h01, 2'h0);
		chk(32'(pinOe), 32'h0);
		funcEn <= 1'b0;
		foreach (KS[j]) begin
			ot(STEP * KS[j] + 4);
			c = (KS[j] < 2) ? 8'h01 : ((KS[j] > 255) ? 8'hff : 8'(KS[j]));
			rd(8'h79, c, 2'h0);
			if (KS[j] < 2) rd(8'h79, 8'h00, 2'h0);
			// The first pulse leaves the count at zero, so only the zero-limit path sets the flag.
			if (j == 0) begin
				rd(8'h42, 8'h20, 2'h0);
				wr(8'h81, 8'h20, 2'h0);
			end
		end
		rd(8'h42, 8'h20, 2'h0);
		wr(8'h81, 8'h20, 2'h0);
		rd(8'h42, 8'h00, 2'h0);
		wr(8'h7a, 8'h03, 2'h0);
		wr(8'h82, 8'h20, 2'h0);
		ot(STEP * 3 + 4);
		rd(8'h42, 8'h00, 2'h0);
		chk(32'(irq), 32'h0);
		ot(STEP * 4 + 4);
		rd(8'h42, 8'h20, 2'h0);
		chk(32'(irq), 32'h1);
		wr(8'h81, 8'h20, 2'h0);
		chk(32'(irq), 32'h0);
		wr(8'h82, 8'h00, 2'h0);
		ot(STEP * 4 + 4);
		chk(32'(irq), 32'h0);
		for (k = 0; k < 12; k++) begin
			c = 8'($urandom);
			tw = 1'($urandom);
			t2 <= 8'($urandom);
			t3 <= 8'($urandom);
			if (k % 4 == 0) begin
				c = tw ? 8'h80 : 8'h00;
			end
			t1 <= (k % 4 == 0) ? 8'h7f : 8'($urandom);
			l1 <= c;
			wr(8'h7c, {7'h10, tw}, 2'h0);
			repeat (2) @(posedge ref_clk);
			chk(32'(otOe), 32'(hot(t1, c, tw)));
			chk(32'(otOut), 32'h0);
		end
		wr(8'h80, 8'h01, 2'h0);
		locked = 1'b1;
		wr(8'h7c, 8'h12, 2'h0);
		rd(8'h7c, 8'(mdl[8'h7c]), 2'h0);
		print_verdict();
	end
endmodule
